/* config_space_defines.vh */
// Constants for the local configuration access block
`ifndef CONFIG_SPACE_DEFINES_VH
`define CONFIG_SPACE_DEFINES_VH

// Local port geometry
`define LOC_ADDR_W 12
`define LOC_DW_LSB 2
`define DW_ADDR_W 10
`define BYTE_W 8
`define WORD_W 32
`define BYTE_CNT_W 2
`define LAST_BYTE 2'h3
`define FIRST_BYTE 2'h0

// Timing
`define LOC_CLK_MAX_MHZ 250
`define VIEW_HOLD_CYCLES 8
`define VIEW_CNT_W 3
`define VIEW_IDX_W 4

// Status vector layout
`define STS_W 53
`define STS_DEV_ERR_HI 52
`define STS_DEV_ERR_LO 49
`define STS_CMD_DONE 47
`define DEV_ERR_W 4

// Hot-plug input layout
`define HP_W 5
`define HP_PWR_CTL 4

// Dword index of slot control/status and bit of command completed in it
`define SLOT_CS_DW 10'h01E
`define SLOT_CMD_DONE_BIT 20

// Write masks of the modelled register space
`define ID_DW 10'h000
`define CMD_STS_DW 10'h001
`define CLASS_DW 10'h002
`define MASK_NONE 32'h0000_0000
`define MASK_CMD 32'h0000_0547
`define MASK_ALL 32'hFFFF_FFFF
`define MASK_SLOT_CS 32'h0000_1FFF

`endif

/* cfg_reg_store.v */
// Configuration register array with per-bit write masks
`timescale 1ns/10ps
`include "config_space_defines.vh"
module cfg_reg_store #(
  parameter DEPTH = 1024
) (
  input wire clock,
  input wire wr_en,
  input wire [`DW_ADDR_W-1:0] wr_addr,
  input wire [`WORD_W-1:0] wr_data,
  input wire [`DW_ADDR_W-1:0] rd_addr,
  output wire [`WORD_W-1:0] rd_data,
  input wire [`DW_ADDR_W-1:0] view_addr,
  output wire [`WORD_W-1:0] view_data
);
  reg [`WORD_W-1:0] mem [0:DEPTH-1];
  integer i;

  // Same mask for every writer, so attributes match on both paths
  function [`WORD_W-1:0] write_mask;
    input [`DW_ADDR_W-1:0] a;
    begin
      case (a)
        `ID_DW: write_mask = `MASK_NONE;
        `CLASS_DW: write_mask = `MASK_NONE;
        `CMD_STS_DW: write_mask = `MASK_CMD;
        `SLOT_CS_DW: write_mask = `MASK_SLOT_CS;
        default: write_mask = `MASK_ALL;
      endcase
    end
  endfunction

  initial begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      mem[i] = `MASK_NONE;
    end
  end

  always @(posedge clock) begin
    if (wr_en) begin
      // Read-only bits keep their value (see RULE3) (see RULE13)
      mem[wr_addr] <= (mem[wr_addr] & ~write_mask(wr_addr)) |
                      (wr_data & write_mask(wr_addr));
    end
  end

  assign rd_data = mem[rd_addr];
  assign view_data = mem[view_addr];
endmodule // cfg_reg_store

/* config_space_local_access.v */
// Local management access, register view and status vector of the config space
//
// Function
// RULE1 - Local port is synchronous to the application clock, up to 250 MHz.
// RULE2 - Local address decodes as the config space address, same access as link.
// RULE3 - Each bit keeps one access attribute for local and link access.
// RULE4 - A 32-bit word moves in four cycles, low byte first.
// RULE5 - Link requests win; local write waits until none pending, then executes.
// RULE6 - Write acknowledge only after the held write has executed.
// RULE7 - Local reads wait until no link request is pending.
// RULE8 - Application may read anytime; writes meant for header logging or debug.
// RULE9 - Root Port: no local access while link config access is in flight.
// RULE10 - Read data byte [7:0] comes with acknowledge, then up to [31:24].
// RULE11 - Application drives write byte [7:0] with write enable, rest after.
// RULE12 - Twelve-bit local address, bits [1:0] ignored, dword aligned.
// RULE13 - Local writes change writable bits only; read-only bits keep value.
// RULE14 - Separate read and write enables, answered by acknowledge, slave style.
// RULE15 - Four-bit view index advances every 8 clock cycles.
// RULE16 - Thirty-two-bit view data shows the register chosen by the index.
// RULE17 - Fifty-three-bit status vector refreshed every clock cycle.
// RULE18 - View, status vector and hot-plug inputs absent in bypass mode.
// RULE19 - Hot-plug input only for Root Port with slot; Endpoints tie zero.
// RULE20 - Hot-plug bits 0..3: attention, presence, latch open, power fault.
// RULE21 - Hot-plug bit 4 follows power control; sets command completed.
// RULE22 - Missing slot features: tie input to zero, clear capability bit.
// RULE23 - Application samples view outputs mid-window after an index change.
// RULE24 - Status bits [52:49]: unsupported, fatal, non-fatal, correctable errors.
// RULE25 - Application keeps one local operation outstanding until acknowledged.
`timescale 1ns/10ps
`include "config_space_defines.vh"
module config_space_local_access #(
  parameter DEPTH = 1024,
  parameter CFG_BYPASS = 0,
  parameter ROOT_PORT = 0
) (
  input wire clock,
  input wire reset_n,
  // Local management port
  input wire loc_rden,
  input wire loc_wren,
  input wire [`LOC_ADDR_W-1:0] loc_addr,
  input wire [`BYTE_W-1:0] loc_din,
  output reg [`BYTE_W-1:0] loc_dout,
  output reg loc_ack,
  // Configuration requests from the link
  input wire link_cfg_req,
  input wire link_cfg_wr,
  input wire [`DW_ADDR_W-1:0] link_cfg_addr,
  input wire [`WORD_W-1:0] link_cfg_wdata,
  output reg [`WORD_W-1:0] link_cfg_rdata,
  output reg link_cfg_ack,
  // Register view and status
  output reg [`VIEW_IDX_W-1:0] cfg_view_index,
  output reg [`WORD_W-1:0] cfg_view_data,
  output reg [`STS_W-1:0] cfg_status_vector,
  input wire [`STS_W-1:0] core_status,
  input wire [`DEV_ERR_W-1:0] dev_err_flags,
  input wire [`HP_W-1:0] hot_plug_events
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_WR_COLLECT = 5'h02;
  localparam [4:0] ST_WR_HOLD = 5'h04;
  localparam [4:0] ST_RD_HOLD = 5'h08;
  localparam [4:0] ST_RD_SEND = 5'h10;
  localparam VIEW_LAST = `VIEW_HOLD_CYCLES - 1;
  localparam [`VIEW_CNT_W-1:0] VIEW_WRAP = VIEW_LAST[`VIEW_CNT_W-1:0];

  reg [4:0] state;
  reg [4:0] next_state;
  reg [`BYTE_CNT_W-1:0] byte_cnt;
  reg [`BYTE_CNT_W-1:0] next_byte_cnt;
  reg [`DW_ADDR_W-1:0] op_addr;
  reg [`WORD_W-1:0] op_word;
  reg [`WORD_W-1:0] next_op_word;
  reg [`BYTE_W-1:0] next_dout;
  reg next_ack;
  reg [`VIEW_CNT_W-1:0] view_cnt;
  reg cmd_done;
  reg pwr_ctl_prev;

  wire loc_write_go;
  wire link_write;
  wire store_wr;
  wire [`DW_ADDR_W-1:0] store_wr_addr;
  wire [`WORD_W-1:0] store_wr_data;
  wire [`DW_ADDR_W-1:0] store_rd_addr;
  wire [`WORD_W-1:0] store_rd_data;
  wire [`WORD_W-1:0] view_word;
  wire [`HP_W-1:0] hp_in;
  wire cmd_done_set;
  wire cmd_done_clr;
  wire [`WORD_W-1:0] cmd_done_bit;

  // Dword index of a byte address
  function [`DW_ADDR_W-1:0] dword_of;
    input [`LOC_ADDR_W-1:0] a;
    begin
      dword_of = a[`LOC_ADDR_W-1:`LOC_DW_LSB]; // see RULE12 see RULE2
    end
  endfunction

  // Replace one byte lane of a word
  function [`WORD_W-1:0] put_byte;
    input [`WORD_W-1:0] w;
    input [`BYTE_CNT_W-1:0] lane;
    input [`BYTE_W-1:0] b;
    reg [`WORD_W-1:0] r;
    begin
      r = w;
      r[lane*`BYTE_W +: `BYTE_W] = b;
      put_byte = r;
    end
  endfunction

  // Overlay the live command-completed flag on slot status reads
  function [`WORD_W-1:0] with_slot;
    input [`DW_ADDR_W-1:0] a;
    input [`WORD_W-1:0] w;
    input flag;
    reg [`WORD_W-1:0] r;
    begin
      r = w;
      if (a == `SLOT_CS_DW) begin
        r[`SLOT_CMD_DONE_BIT] = flag;
      end
      with_slot = r;
    end
  endfunction

  // Next byte lane, wrapping after the top byte
  function [`BYTE_CNT_W-1:0] next_lane;
    input [`BYTE_CNT_W-1:0] lane;
    begin
      next_lane = lane + 2'h1;
    end
  endfunction

  // Dword shown at a view index
  function [`DW_ADDR_W-1:0] view_dword;
    input [`VIEW_IDX_W-1:0] idx;
    begin
      view_dword = {{(`DW_ADDR_W-`VIEW_IDX_W){1'b0}}, idx};
    end
  endfunction

  assign cmd_done_bit = `MASK_NONE | (32'h1 << `SLOT_CMD_DONE_BIT);

  // Link always owns the write port when it asks
  assign link_write = link_cfg_req & link_cfg_wr; // see RULE5
  assign loc_write_go = (state == ST_WR_HOLD) & ~link_cfg_req; // see RULE5
  assign store_wr = link_write | loc_write_go;
  assign store_wr_addr = link_write ? link_cfg_addr : op_addr;
  assign store_wr_data = link_write ? link_cfg_wdata : op_word;
  assign store_rd_addr = link_cfg_req ? link_cfg_addr : op_addr;

  cfg_reg_store #(
    .DEPTH(DEPTH)
  ) cfg_reg_store_i (
    .clock(clock),
    .wr_en(store_wr),
    .wr_addr(store_wr_addr),
    .wr_data(store_wr_data),
    .rd_addr(store_rd_addr),
    .rd_data(store_rd_data),
    .view_addr(view_dword(cfg_view_index)),
    .view_data(view_word)
  );

  // Local access sequencer, all on the application clock (see RULE1)
  always @* begin
    next_state = state;
    next_byte_cnt = byte_cnt;
    next_op_word = op_word;
    next_dout = {`BYTE_W{1'b0}};
    next_ack = 1'b0;
    case (state)
      ST_IDLE: begin
        if (loc_wren) begin
          // Low byte arrives with write enable (see RULE11) (see RULE4)
          next_op_word = put_byte(`MASK_NONE, `FIRST_BYTE, loc_din);
          next_byte_cnt = next_lane(`FIRST_BYTE);
          next_state = ST_WR_COLLECT;
        end else if (loc_rden) begin
          next_state = ST_RD_HOLD; // see RULE14
        end
      end
      ST_WR_COLLECT: begin
        // Bytes gathered regardless of link traffic; only the commit waits
        next_op_word = put_byte(op_word, byte_cnt, loc_din); // see RULE4
        next_byte_cnt = next_lane(byte_cnt);
        if (byte_cnt == `LAST_BYTE) begin
          next_state = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        if (!link_cfg_req) begin
          // Acknowledge once the write has been committed (see RULE6)
          next_ack = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_RD_HOLD: begin
        if (!link_cfg_req) begin
          // Deferred read, low byte with acknowledge (see RULE7) (see RULE10)
          next_op_word = with_slot(op_addr, store_rd_data, cmd_done);
          next_dout = next_op_word[`BYTE_W-1:0];
          next_ack = 1'b1;
          next_byte_cnt = next_lane(`FIRST_BYTE);
          next_state = ST_RD_SEND;
        end
      end
      ST_RD_SEND: begin
        next_dout = op_word[byte_cnt*`BYTE_W +: `BYTE_W]; // see RULE10 see RULE4
        next_byte_cnt = next_lane(byte_cnt);
        if (byte_cnt == `LAST_BYTE) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      byte_cnt <= `FIRST_BYTE;
      op_addr <= {`DW_ADDR_W{1'b0}};
      op_word <= `MASK_NONE;
      loc_dout <= 8'h00;
      loc_ack <= 1'b0;
    end else begin
      state <= next_state;
      byte_cnt <= next_byte_cnt;
      op_word <= next_op_word;
      loc_dout <= next_dout;
      loc_ack <= next_ack;
      if (state == ST_IDLE && (loc_wren || loc_rden)) begin
        op_addr <= dword_of(loc_addr); // see RULE12
      end
    end
  end

  // Link requests served in the cycle they are seen
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      link_cfg_rdata <= `MASK_NONE;
      link_cfg_ack <= 1'b0;
    end else begin
      link_cfg_ack <= link_cfg_req; // see RULE5
      if (link_cfg_req && !link_cfg_wr) begin
        link_cfg_rdata <= with_slot(link_cfg_addr, store_rd_data, cmd_done); // see RULE2
      end
    end
  end

  // Hot-plug inputs ignored when not a Root Port or in bypass
  assign hp_in = (CFG_BYPASS == 0 && ROOT_PORT != 0) ?
                 hot_plug_events : {`HP_W{1'b0}}; // see RULE18 see RULE19
  assign cmd_done_set = hp_in[`HP_PWR_CTL] ^ pwr_ctl_prev; // see RULE21
  // Write-one-to-clear from either path; a new event wins over the clear
  assign cmd_done_clr = store_wr && (store_wr_addr == `SLOT_CS_DW) &&
                        ((store_wr_data & cmd_done_bit) != `MASK_NONE);

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pwr_ctl_prev <= 1'b0;
      cmd_done <= 1'b0;
    end else begin
      pwr_ctl_prev <= hp_in[`HP_PWR_CTL];
      if (cmd_done_set) begin
        cmd_done <= 1'b1; // see RULE21
      end else if (cmd_done_clr) begin
        cmd_done <= 1'b0;
      end
    end
  end

  // Register view and status vector; held at zero in bypass
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      view_cnt <= {`VIEW_CNT_W{1'b0}};
      cfg_view_index <= {`VIEW_IDX_W{1'b0}};
      cfg_view_data <= `MASK_NONE;
      cfg_status_vector <= {`STS_W{1'b0}};
    end else if (CFG_BYPASS != 0) begin
      view_cnt <= {`VIEW_CNT_W{1'b0}}; // see RULE18
      cfg_view_index <= {`VIEW_IDX_W{1'b0}};
      cfg_view_data <= `MASK_NONE;
      cfg_status_vector <= {`STS_W{1'b0}};
    end else begin
      view_cnt <= view_cnt + 3'h1;
      if (view_cnt == VIEW_WRAP) begin
        cfg_view_index <= cfg_view_index + 4'h1; // see RULE15
      end
      cfg_view_data <= with_slot(view_dword(cfg_view_index), view_word, cmd_done); // see RULE16
      cfg_status_vector <= core_status; // see RULE17
      cfg_status_vector[`STS_DEV_ERR_HI:`STS_DEV_ERR_LO] <= dev_err_flags; // see RULE24
      cfg_status_vector[`STS_CMD_DONE] <= cmd_done; // see RULE21
    end
  end

endmodule // config_space_local_access

/* config_space_local_access_properties.sv */
// Port-level assertions for the local config access block
`timescale 1ns/10ps
`include "config_space_defines.vh"
module cfg_access_props (
  input wire clock,
  input wire reset_n,
  input wire loc_rden,
  input wire loc_wren,
  input wire loc_ack,
  input wire link_cfg_req,
  input wire link_cfg_ack,
  input wire [`VIEW_IDX_W-1:0] cfg_view_index,
  input wire [`STS_W-1:0] cfg_status_vector,
  input wire [`STS_W-1:0] core_status,
  input wire [`DEV_ERR_W-1:0] dev_err_flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Quiet link: four data beats, commit, then ack
  wr_ack_time_a: assert property ((loc_wren && !link_cfg_req) ##1
    (!link_cfg_req) [*4] |=> loc_ack)
    else $error("write ack late or missing");
  rd_ack_time_a: assert property ((loc_rden && !loc_wren && !link_cfg_req) ##1
    !link_cfg_req |=> loc_ack)
    else $error("read ack late or missing");
  ack_held_a: assert property (loc_ack |-> !$past(link_cfg_req))
    else $error("local access finished while link request pending");
  ack_pulse_a: assert property (loc_ack |=> !loc_ack)
    else $error("ack longer than one cycle");
  link_ack_a: assert property (link_cfg_ack == $past(link_cfg_req))
    else $error("link request not served at once");
  view_step_a: assert property ($changed(cfg_view_index) |->
    cfg_view_index == $past(cfg_view_index) + 4'h1)
    else $error("view index skipped");
  view_hold_a: assert property ($changed(cfg_view_index) |=>
    $stable(cfg_view_index) [*7])
    else $error("view index held under eight cycles");
  status_err_a: assert property (
    cfg_status_vector[`STS_DEV_ERR_HI:`STS_DEV_ERR_LO] == $past(dev_err_flags))
    else $error("error flags not in status vector");
  // Bit 47 is register state, not a copy, so it is left out here
  status_copy_a: assert property (
    {cfg_status_vector[48], cfg_status_vector[46:0]} ==
    $past({core_status[48], core_status[46:0]}))
    else $error("status vector not refreshed");
endmodule // cfg_access_props
bind config_space_local_access cfg_access_props cfg_access_props_i (
  .clock(clock), .reset_n(reset_n), .loc_rden(loc_rden), .loc_wren(loc_wren),
  .loc_ack(loc_ack), .link_cfg_req(link_cfg_req), .link_cfg_ack(link_cfg_ack),
  .cfg_view_index(cfg_view_index), .cfg_status_vector(cfg_status_vector),
  .core_status(core_status), .dev_err_flags(dev_err_flags));

/* app_view_sampler.sv */
// Application-side sampler of the multiplexed register view
`timescale 1ns/10ps
module app_view_sampler (
  input wire clock,
  input wire reset_n,
  input wire [3:0] cfg_view_index,
  input wire [31:0] cfg_view_data,
  output reg cap_valid,
  output reg [3:0] cap_index,
  output reg [31:0] cap_data
);
  reg last_lsb;
  reg [2:0] chg;
  // Sample four cycles after an index change, well inside the window
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last_lsb <= 1'b0;
      chg <= 3'h0;
      cap_valid <= 1'b0;
      cap_index <= 4'h0;
      cap_data <= 32'h0;
    end else begin
      last_lsb <= cfg_view_index[0];
      chg <= {chg[1:0], last_lsb != cfg_view_index[0]};
      cap_valid <= chg[2];
      if (chg[2]) begin
        cap_index <= cfg_view_index;
        cap_data <= cfg_view_data;
      end
    end
  end
endmodule // app_view_sampler

/* test_config_space_local_access.sv */
// Self-checking bench for the local config access block
`timescale 1ns/10ps
module test_config_space_local_access;
  reg clock, reset_n, loc_rden, loc_wren, link_cfg_req, link_cfg_wr, view_on;
  reg [11:0] loc_addr;
  reg [7:0] loc_din;
  reg [9:0] link_cfg_addr;
  reg [31:0] link_cfg_wdata, w, got;
  reg [52:0] core_status;
  reg [3:0] dev_err_flags;
  reg [4:0] hot_plug_events;
  wire [7:0] loc_dout;
  wire loc_ack, link_cfg_ack, cap_valid;
  wire [31:0] link_cfg_rdata, cfg_view_data, cap_data;
  wire [3:0] cfg_view_index, cap_index;
  wire [52:0] cfg_status_vector;
  reg [31:0] shadow [0:31];
  reg [32:0] exp_q [$];
  reg [32:0] e;
  integer n_fail = 0, checks = 0, seed = 32'hBBE3, i, d;
  // Root Port with a slot, so the hot-plug inputs are live
  config_space_local_access #(.DEPTH(1024), .CFG_BYPASS(0), .ROOT_PORT(1))
    config_space_local_access_i (
    .clock(clock), .reset_n(reset_n), .loc_rden(loc_rden), .loc_wren(loc_wren),
    .loc_addr(loc_addr), .loc_din(loc_din), .loc_dout(loc_dout), .loc_ack(loc_ack),
    .link_cfg_req(link_cfg_req), .link_cfg_wr(link_cfg_wr), .link_cfg_addr(link_cfg_addr),
    .link_cfg_wdata(link_cfg_wdata), .link_cfg_rdata(link_cfg_rdata), .link_cfg_ack(link_cfg_ack),
    .cfg_view_index(cfg_view_index), .cfg_view_data(cfg_view_data),
    .cfg_status_vector(cfg_status_vector), .core_status(core_status),
    .dev_err_flags(dev_err_flags), .hot_plug_events(hot_plug_events));
  app_view_sampler app_view_sampler_i (.clock(clock), .reset_n(reset_n),
    .cfg_view_index(cfg_view_index), .cfg_view_data(cfg_view_data),
    .cap_valid(cap_valid), .cap_index(cap_index), .cap_data(cap_data));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  task check(input string name, input [31:0] exp, input [31:0] seen);
    checks = checks + 1;
    if (exp !== seen) begin
      n_fail = n_fail + 1;
      $display("MISMATCH %0s exp %h got %h", name, exp, seen);
    end
  endtask
  task end_of_test;
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wait_ack;
    integer n;
    n = 0;
    while (loc_ack !== 1'b1 && n < 60) begin
      @(negedge clock);
      n = n + 1;
    end
    check("loc_ack", 1, {31'h0, loc_ack});
  endtask
  task lwrite(input [11:0] a, input [31:0] v);
    integer k;
    exp_q.push_back({1'b0, v});
    @(negedge clock);
    loc_wren = 1;
    loc_addr = a;
    loc_din = v[7:0];
    for (k = 1; k < 4; k = k + 1) begin
      @(negedge clock);
      loc_wren = 0;
      loc_din = v[8*k +: 8];
    end
    wait_ack;
    // Dwords 0 and 2 read-only, dword 1 partly writable
    if (a[11:2] == 10'h001) shadow[1] = (shadow[1] & ~32'h0000_0547) | (v & 32'h0000_0547);
    else if (a[11:2] != 10'h000 && a[11:2] != 10'h002) shadow[a[6:2]] = v;
  endtask
  task lread(input [11:0] a, input [31:0] v);
    exp_q.push_back({1'b1, v});
    @(negedge clock);
    loc_rden = 1;
    loc_addr = a;
    @(negedge clock);
    loc_rden = 0;
    wait_ack;
    repeat (4) @(negedge clock);
  endtask
  task link_op(input wr, input [9:0] a, input [31:0] v, input integer cyc);
    @(negedge clock);
    link_cfg_req = 1;
    link_cfg_wr = wr;
    link_cfg_addr = a;
    link_cfg_wdata = v;
    repeat (cyc) @(negedge clock);
    link_cfg_req = 0;
  endtask
  initial forever begin
    @(negedge clock);
    if (loc_ack === 1'b1) begin
      e = exp_q.pop_front();
      if (e[32]) begin
        for (i = 0; i < 4; i = i + 1) begin
          got[8*i +: 8] = loc_dout;
          @(negedge clock);
        end
        check("loc_dout", e[31:0], got);
        check("dout_idle", 0, {24'h0, loc_dout});
      end
    end
  end
  always @(negedge clock) begin
    if (view_on && cap_valid === 1'b1) check("view", shadow[cap_index], cap_data);
  end
  initial begin
    wait (reset_n === 1'b1);
    forever begin
      @(negedge clock);
      core_status = {21'($random(seed)), 32'($random(seed))};
      dev_err_flags = 4'($random(seed));
    end
  end
  initial begin
    #60000;
    n_fail = n_fail + 1;
    end_of_test;
  end
  initial begin
    {reset_n, loc_rden, loc_wren, loc_addr, loc_din, link_cfg_req, link_cfg_wr} = 0;
    {link_cfg_addr, link_cfg_wdata, core_status, dev_err_flags, hot_plug_events, view_on} = 0;
    for (d = 0; d < 32; d = d + 1) shadow[d] = 0;
    repeat (4) @(negedge clock);
    reset_n = 1;
    for (d = 0; d < 16; d = d + 1) begin
      w = $random(seed);
      lwrite({d[9:0], d[1:0]}, w);
      lread({d[9:0], 2'b00}, shadow[d]);
    end
    link_op(0, 10'h005, 0, 1);
    check("link_rd", shadow[5], link_cfg_rdata);
    link_op(1, 10'h000, 32'hFFFF_FFFF, 1);
    lread(12'h000, shadow[0]);
    w = $random(seed);
    // Link write to the same dword while the local write is held
    fork
      lwrite(12'h010, w);
      begin
        @(negedge clock);
        link_op(1, 10'h004, ~w, 6);
      end
    join
    link_op(0, 10'h004, 0, 1);
    check("link_rd", w, link_cfg_rdata);
    fork
      lread(12'h010, w);
      link_op(0, 10'h002, 0, 5);
    join
    check("link_rd", 0, link_cfg_rdata);
    // Only the power-control bit moves; slot has no button, latch or fault logic
    hot_plug_events = 5'h10;
    repeat (3) @(negedge clock);
    check("sts_cmd_done", 1, {31'h0, cfg_status_vector[47]});
    lread(12'h078, 32'h0010_0000);
    // Write-one-to-clear; the flag is not a writable store bit
    lwrite(12'h078, 32'h0010_0000);
    lread(12'h078, 32'h0000_0000);
    view_on = 1;
    repeat (140) @(negedge clock);
    end_of_test;
  end
endmodule // test_config_space_local_access
